// >>> verilog/pcsr_defines.vh
/*
 Constants of the PCS managed register bank: register offsets,
 field positions, reset values and write masks.
 Assumes it is included by its bare name from verilog/ sources.
*/
`ifndef PCSR_DEFINES_VH
`define PCSR_DEFINES_VH

// ==========================================================
// Register offsets on the serial management bus
`define PCSR_REG_CONTROL 5'h00
`define PCSR_REG_STATUS 5'h01
`define PCSR_REG_ID_HIGH 5'h02
`define PCSR_REG_ID_LOW 5'h03
`define PCSR_REG_ADV 5'h04
`define PCSR_REG_PARTNER 5'h05
`define PCSR_REG_EXPANSION 5'h06
`define PCSR_REG_NP_TX 5'h07
`define PCSR_REG_NP_RX 5'h08
`define PCSR_REG_EXT_STATUS 5'h0f

// ==========================================================
// Field positions
`define PCSR_CTRL_RESTART 9
`define PCSR_ST_EXT_STATUS 8
`define PCSR_ST_PREAMBLE 6
`define PCSR_ST_AN_DONE 5
`define PCSR_ST_RFAULT 4
`define PCSR_ST_AN_ABLE 3
`define PCSR_ST_LINK 2
`define PCSR_ADV_RF_HI 13
`define PCSR_ADV_RF_LO 12
`define PCSR_EXP_NP_ABLE 2
`define PCSR_EXP_PAGE_RX 1
`define PCSR_NP_TOGGLE 11

// ==========================================================
// Reset values and masks
`define PCSR_ADV_RESET 16'h01a0
`define PCSR_ADV_WMASK 16'hb1a0
`define PCSR_NP_TX_RESET 16'h2001
`define PCSR_NP_TX_WMASK 16'hb7ff
`define PCSR_PARTNER_MASK 16'hf1e0
`define PCSR_NP_RX_MASK 16'hffff
`define PCSR_EXT_STATUS_VAL 16'h8000
`define PCSR_WORD_ZERO 16'h0000
`define PCSR_PIN_IDLE 2'b10

// ==========================================================
// Serial frame fields
`define PCSR_OP_READ 2'b10
`define PCSR_OP_WRITE 2'b01
`define PCSR_HDR_LAST 5'h0b
`define PCSR_DATA_LAST 5'h0f
`define PCSR_RD_RELEASE 5'h10
`define PCSR_SKIP_LAST 5'h11

`endif

// >>> verilog/pcsr_mdio_slave.v
/*
 Serial management frame engine: decodes frames, raises one-cycle
 read and write strobes, and drives read data onto the data pin.
 Assumes mdc_s and mdio_s are already synchronised to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pcsr_defines.vh"

module pcsr_mdio_slave (
    input wire clk_sys,
    input wire rst_n,
    input wire mdc_s,
    input wire mdio_s,
    input wire [4:0] phy_addr,
    input wire [15:0] rd_data,
    output reg rd_req,
    output reg wr_req,
    output reg [4:0] reg_addr,
    output reg [15:0] wr_data,
    output reg mdio_out,
    output reg mdio_oe
);

localparam S_IDLE = 3'd0;
localparam S_START = 3'd1;
localparam S_HDR = 3'd2;
localparam S_TA_RD = 3'd3;
localparam S_RD = 3'd4;
localparam S_TA_WR = 3'd5;
localparam S_WR = 3'd6;
localparam S_SKIP = 3'd7;

reg [2:0] state_reg;
reg [4:0] cnt_reg;
reg [15:0] sh_reg;
reg mdc_d_reg;
wire rise;
wire [15:0] sh_in;

assign rise = mdc_s & ~mdc_d_reg;
assign sh_in = {sh_reg[14:0], mdio_s};

// ==========================================================
// Frame sequencer
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= S_IDLE;
        cnt_reg <= 5'h00;
        sh_reg <= 16'h0000;
        mdc_d_reg <= 1'b0;
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        reg_addr <= 5'h00;
        wr_data <= 16'h0000;
        mdio_out <= 1'b0;
        mdio_oe <= 1'b0;
    end else begin
        mdc_d_reg <= mdc_s;
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        if (rise) begin
            case (state_reg)
                S_IDLE: begin
                    if (!mdio_s) begin
                        state_reg <= S_START;
                    end
                end
                S_START: begin
                    if (mdio_s) begin
                        state_reg <= S_HDR;
                        cnt_reg <= 5'h00;
                    end
                end
                S_HDR: begin
                    sh_reg <= sh_in;
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == `PCSR_HDR_LAST) begin
                        cnt_reg <= 5'h00;
                        reg_addr <= sh_in[4:0];
                        if (sh_in[9:5] != phy_addr) begin
                            state_reg <= S_SKIP;
                        end else if (sh_in[11:10] == `PCSR_OP_READ) begin
                            rd_req <= 1'b1;
                            state_reg <= S_TA_RD;
                        end else if (sh_in[11:10] == `PCSR_OP_WRITE) begin
                            state_reg <= S_TA_WR;
                        end else begin
                            state_reg <= S_SKIP;
                        end
                    end
                end
                // Second turnaround bit driven low
                S_TA_RD: begin
                    mdio_out <= 1'b0;
                    mdio_oe <= 1'b1;
                    sh_reg <= rd_data;
                    state_reg <= S_RD;
                end
                S_RD: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == `PCSR_RD_RELEASE) begin
                        mdio_oe <= 1'b0;
                        mdio_out <= 1'b0;
                        state_reg <= S_IDLE;
                    end else begin
                        mdio_out <= sh_reg[15];
                        sh_reg <= {sh_reg[14:0], 1'b0};
                    end
                end
                S_TA_WR: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == 5'h01) begin
                        cnt_reg <= 5'h00;
                        state_reg <= S_WR;
                    end
                end
                S_WR: begin
                    sh_reg <= sh_in;
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == `PCSR_DATA_LAST) begin
                        wr_data <= sh_in;
                        wr_req <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                // Frame for another device or with an unknown opcode: sit it out
                S_SKIP: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == `PCSR_SKIP_LAST) begin
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
end

endmodule

`default_nettype wire

// >>> verilog/pcsr_regbank.v
/*
 PCS managed register bank for 1000BASE-X auto-negotiation, reached
 over the serial management pins. Holds status, identifier,
 advertisement, partner ability, expansion, next page and extended
 status registers.
 Assumes the negotiation state machine runs on clk_sys and gives
 one-cycle strobes; mdc and mdio_in come from outside the domain.
*/
// Operation
// - Preamble suppression status bit reads one
// - Completion bit follows negotiation, resets zero
// - Remote fault latched, cleared by status read
// - Negotiation ability bit reads one
// - Jabber and bit seven read zero
// - Extended capability bit reads zero
// - Writable next page advertise bit, default zero
// - Advertised fault writable, reverts after negotiation
// - Advertised pause writable, resets to three
// - Half duplex zero, full duplex writable one
// - Advertisement reserved bits read zero
// - Partner ability read-only, captured base page
// - Acknowledge bits from received pages
// - Next page able reads one, rest zero except page received
// - Page received set on page, read-cleared
// - Next page transmit control fields writable
// - Code field writable, resets null message
// - Toggle flips per next page sent
// - Next page receive captures partner page
// - Extended status: only full duplex one
// - All registers over serial management frames
// - Extended status present bit reads one
// - Restart bit pulses restart, self-clears
`timescale 1ns/10ps
`default_nettype none
`include "pcsr_defines.vh"

module pcsr_regbank #(
    parameter [4:0] PHY_ADDR = 5'h01,
    // Identifier values are arbitrary
    parameter [15:0] ID_HIGH = 16'h0a1b,
    parameter [15:0] ID_LOW = 16'h2c3d
) (
    input wire clk_sys,
    input wire rstn,
    input wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe,
    input wire an_complete,
    input wire an_remote_fault,
    input wire link_up,
    input wire [15:0] base_page_rx,
    input wire base_page_stb,
    input wire [15:0] next_page_rx,
    input wire next_page_stb,
    input wire next_page_sent,
    output reg [15:0] adv_page,
    output reg [15:0] np_tx_page,
    output reg an_restart
);

// ==========================================================
// Reset release
// Asserts at once, lifts on a clock edge
reg rst_meta_reg;
reg rst_sync_reg;
wire rst_n;

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        rst_meta_reg <= 1'b0;
        rst_sync_reg <= 1'b0;
    end else begin
        rst_meta_reg <= 1'b1;
        rst_sync_reg <= rst_meta_reg;
    end
end

assign rst_n = rst_sync_reg;

// ==========================================================
// Pin synchronisers
// Bit 0 carries the clock pin, bit 1 the data pin
// Idle levels on reset, so no false clock edge follows
localparam [1:0] PIN_IDLE = `PCSR_PIN_IDLE;
wire [1:0] pin_raw;
reg [1:0] pin_meta_reg;
reg [1:0] pin_sync_reg;
wire mdc_s;
wire mdio_s;

assign pin_raw = {mdio_in, mdc};

genvar pin_i;
generate
    for (pin_i = 0; pin_i < 2; pin_i = pin_i + 1) begin : g_pin_sync
        always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                pin_meta_reg[pin_i] <= PIN_IDLE[pin_i];
                pin_sync_reg[pin_i] <= PIN_IDLE[pin_i];
            end else begin
                pin_meta_reg[pin_i] <= pin_raw[pin_i];
                pin_sync_reg[pin_i] <= pin_meta_reg[pin_i];
            end
        end
    end
endgenerate

assign mdc_s = pin_sync_reg[0];
assign mdio_s = pin_sync_reg[1];

// ==========================================================
// Frame engine
// Engine sees only the synchronised pins
wire rd_req;
wire wr_req;
wire [4:0] reg_addr;
wire [15:0] wr_data;
wire eng_out;
wire eng_oe;
reg [15:0] rd_data_reg;

pcsr_mdio_slave u_slave (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mdc_s(mdc_s),
    .mdio_s(mdio_s),
    .phy_addr(PHY_ADDR),
    .rd_data(rd_data_reg),
    .rd_req(rd_req),
    .wr_req(wr_req),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .mdio_out(eng_out),
    .mdio_oe(eng_oe)
);

// Pin drive retimed so top outputs come from local flops
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        mdio_out <= 1'b0;
        mdio_oe <= 1'b0;
    end else begin
        mdio_out <= eng_out;
        mdio_oe <= eng_oe;
    end
end

// ==========================================================
// Access decode
// Strobes last one cycle, so each read clears once
function hit;
    input req;
    input [4:0] addr;
    input [4:0] target;
    begin
        hit = req & (addr == target);
    end
endfunction

wire rd_status;
wire rd_expansion;
wire wr_control;
wire wr_adv;
wire wr_np_tx;
wire restart_req;

assign rd_status = hit(rd_req, reg_addr, `PCSR_REG_STATUS);
assign rd_expansion = hit(rd_req, reg_addr, `PCSR_REG_EXPANSION);
assign wr_control = hit(wr_req, reg_addr, `PCSR_REG_CONTROL);
assign wr_adv = hit(wr_req, reg_addr, `PCSR_REG_ADV);
assign wr_np_tx = hit(wr_req, reg_addr, `PCSR_REG_NP_TX);
assign restart_req = wr_control & wr_data[`PCSR_CTRL_RESTART];

// ==========================================================
// Status and event flags
// Events stay latched until the controller reads
reg an_done_reg;
reg rfault_reg;
reg link_reg;
reg page_rx_reg;
reg rfault_next;
reg link_next;
reg page_rx_next;
wire an_done_rise;

assign an_done_rise = an_complete & ~an_done_reg;

always @* begin
    rfault_next = an_remote_fault | (rfault_reg & ~rd_status);
    link_next = link_up & (rd_status | link_reg);
    page_rx_next = base_page_stb | next_page_stb |
                   (page_rx_reg & ~rd_expansion);
end

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        an_done_reg <= 1'b0;
        rfault_reg <= 1'b0;
        link_reg <= 1'b0;
        page_rx_reg <= 1'b0;
    end else begin
        an_done_reg <= an_complete;
        rfault_reg <= rfault_next;
        link_reg <= link_next;
        page_rx_reg <= page_rx_next;
    end
end

// ==========================================================
// Writable registers
// A write and a page event may share a cycle
reg [15:0] adv_next;
reg [15:0] np_tx_next;

always @* begin
    adv_next = adv_page;
    if (wr_adv) begin
        adv_next = wr_data & `PCSR_ADV_WMASK;
    end
    if (an_done_rise) begin
        adv_next[`PCSR_ADV_RF_HI:`PCSR_ADV_RF_LO] = 2'b00;
    end
    np_tx_next = np_tx_page;
    if (wr_np_tx) begin
        np_tx_next = (wr_data & `PCSR_NP_TX_WMASK) |
                     (np_tx_page & ~`PCSR_NP_TX_WMASK);
    end
    if (next_page_sent) begin
        np_tx_next[`PCSR_NP_TOGGLE] = ~np_tx_page[`PCSR_NP_TOGGLE];
    end
end

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        adv_page <= `PCSR_ADV_RESET;
        np_tx_page <= `PCSR_NP_TX_RESET;
        an_restart <= 1'b0;
    end else begin
        adv_page <= adv_next;
        np_tx_page <= np_tx_next;
        an_restart <= restart_req;
    end
end

// ==========================================================
// Received page capture
// Words held until the next strobe
reg [15:0] partner_reg;
reg [15:0] np_rx_reg;

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        partner_reg <= 16'h0000;
        np_rx_reg <= 16'h0000;
    end else begin
        if (base_page_stb) begin
            partner_reg <= base_page_rx & `PCSR_PARTNER_MASK;
        end
        if (next_page_stb) begin
            np_rx_reg <= next_page_rx & `PCSR_NP_RX_MASK;
        end
    end
end

// ==========================================================
// Read-only images
reg [15:0] status_word;
reg [15:0] exp_word;

always @* begin
    status_word = 16'h0000;
    status_word[`PCSR_ST_EXT_STATUS] = 1'b1;
    status_word[`PCSR_ST_PREAMBLE] = 1'b1;
    status_word[`PCSR_ST_AN_DONE] = an_done_reg;
    status_word[`PCSR_ST_RFAULT] = rfault_reg;
    status_word[`PCSR_ST_AN_ABLE] = 1'b1;
    status_word[`PCSR_ST_LINK] = link_reg;
    exp_word = 16'h0000;
    exp_word[`PCSR_EXP_NP_ABLE] = 1'b1;
    exp_word[`PCSR_EXP_PAGE_RX] = page_rx_reg;
end

// ==========================================================
// Read multiplexer
// Unmapped addresses read zero
reg [15:0] rd_mux;

always @* begin
    case (reg_addr)
        `PCSR_REG_STATUS: rd_mux = status_word;
        `PCSR_REG_ID_HIGH: rd_mux = ID_HIGH;
        `PCSR_REG_ID_LOW: rd_mux = ID_LOW;
        `PCSR_REG_ADV: rd_mux = adv_page;
        `PCSR_REG_PARTNER: rd_mux = partner_reg;
        `PCSR_REG_EXPANSION: rd_mux = exp_word;
        `PCSR_REG_NP_TX: rd_mux = np_tx_page;
        `PCSR_REG_NP_RX: rd_mux = np_rx_reg;
        `PCSR_REG_EXT_STATUS: rd_mux = `PCSR_EXT_STATUS_VAL;
        default: rd_mux = `PCSR_WORD_ZERO;
    endcase
end

// Snapshot taken in the same cycle as the read clears,
// so a latched event is reported exactly once.
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        rd_data_reg <= 16'h0000;
    end else if (rd_req) begin
        rd_data_reg <= rd_mux;
    end
end

endmodule

`default_nettype wire

// >>> tb/pcsr_mdio_master.sv
/*
 Management controller model: sends serial frames, reads answers.
 Assumes the bank's pin outputs and a pull-up on the data line.
*/
`timescale 1ns/10ps
`default_nettype none
module pcsr_mdio_master (
    input wire logic clk_sys,
    output logic mdc,
    output logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    logic m_oe = 1'b0;
    logic m_d = 1'b0;
    initial mdc = 1'b0;
    // ==========================================================
    // Wire level
    // Pull-up wins when nobody drives the line
    assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_d : 1'b1);
    // ==========================================================
    // Frame transfer
    // frames without preamble, clock idle low between
    task automatic xfer(input logic [4:0] pa, input logic [1:0] op,
        input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rd);
        logic [31:0] f;
        f = {2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 31; i >= 0; i--) begin
            m_oe <= !(op == 2'b10 && i < 18);
            m_d <= f[i];
            repeat (20) @(posedge clk_sys);
            // Slave moves the line after a rise, so take it before one
            rd = {rd[14:0], mdio_in};
            mdc <= 1'b1;
            repeat (20) @(posedge clk_sys);
            mdc <= 1'b0;
        end
        m_oe <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// >>> tb/pcsr_regbank_monitor.sv
/*
 Port checker of the register bank, bound into it.
 Assumes one clock domain and the active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pcsr_regbank_monitor (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic an_complete,
    input wire logic an_remote_fault,
    input wire logic link_up,
    input wire logic [15:0] base_page_rx,
    input wire logic base_page_stb,
    input wire logic [15:0] next_page_rx,
    input wire logic next_page_stb,
    input wire logic next_page_sent,
    input wire logic [15:0] adv_page,
    input wire logic [15:0] np_tx_page,
    input wire logic an_restart
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // Register images
    adv_resv_zero_a: assert property ((adv_page & 16'h4e5f) == 16'h0)
        else $error("adv reserved bit set");
    np_bit14_zero_a: assert property (!np_tx_page[14])
        else $error("np bit 14 set");
    adv_reset_val_a: assert property ($rose(rstn) |-> adv_page == 16'h01a0)
        else $error("adv reset value");
    np_reset_val_a: assert property ($rose(rstn) |-> np_tx_page == 16'h2001)
        else $error("np reset value");
    toggle_flip_a: assert property (next_page_sent |=>
        np_tx_page[11] != $past(np_tx_page[11])) else $error("no toggle");
    toggle_hold_a: assert property (!next_page_sent |=>
        $stable(np_tx_page[11])) else $error("stray toggle");
    fault_clear_a: assert property ($rose(an_complete) |->
        ##[1:2] adv_page[13:12] == 2'b00) else $error("fault kept");
    // ==========================================================
    // Pins and strobes
    restart_pulse_a: assert property (an_restart |=> !an_restart)
        else $error("restart too long");
    ta_low_a: assert property ($rose(mdio_oe) |-> !mdio_out)
        else $error("turnaround not low");
    pin_after_rise_a: assert property ($changed(mdio_oe) |-> mdc)
        else $error("pin moved in low half");
    read_c: cover property ($rose(mdio_oe));
    restart_c: cover property (an_restart);
    toggle_c: cover property (next_page_sent);
endmodule
bind pcsr_regbank pcsr_regbank_monitor mon_u (.clk_sys(clk_sys),
    .rstn(rstn), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .an_complete(an_complete),
    .an_remote_fault(an_remote_fault), .link_up(link_up),
    .base_page_rx(base_page_rx), .base_page_stb(base_page_stb),
    .next_page_rx(next_page_rx), .next_page_stb(next_page_stb),
    .next_page_sent(next_page_sent), .adv_page(adv_page),
    .np_tx_page(np_tx_page), .an_restart(an_restart));
`default_nettype wire

// >>> tb/tb.sv
/*
 Self-checking bench of the register bank over serial frames.
 Assumes the controller model and the bound port checker.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_sys, rstn, mdc, mdio_in, mdio_out, mdio_oe, an_restart;
    logic an_complete = 1'b0;
    logic link_up = 1'b1;
    logic [15:0] base_page_rx = 16'h0, next_page_rx = 16'h0;
    logic [15:0] adv_page, np_tx_page, rs_n = 16'h0, d;
    logic an_remote_fault, base_page_stb, next_page_stb, next_page_sent;
    logic [3:0] ev = 4'h0;
    int mismatches = 0, compares = 0;
    localparam logic [4:0] RA [13] = '{5'h01, 5'h01, 5'h02, 5'h03,
        5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0f, 5'h00, 5'h09, 5'h1f};
    localparam logic [15:0] EX [13] = '{16'h0148, 16'h014c, 16'h0a1b,
        16'h2c3d, 16'h01a0, 16'h0, 16'h0004, 16'h2001, 16'h0, 16'h8000,
        16'h0, 16'h0, 16'h0};
    assign {an_remote_fault, base_page_stb, next_page_stb,
        next_page_sent} = ev;
    pcsr_regbank dut_u (.clk_sys(clk_sys), .rstn(rstn), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .an_complete(an_complete), .an_remote_fault(an_remote_fault),
        .link_up(link_up), .base_page_rx(base_page_rx),
        .base_page_stb(base_page_stb), .next_page_rx(next_page_rx),
        .next_page_stb(next_page_stb), .next_page_sent(next_page_sent),
        .adv_page(adv_page), .np_tx_page(np_tx_page),
        .an_restart(an_restart));
    pcsr_mdio_master mm_u (.clk_sys(clk_sys), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
    // ==========================================================
    // Helpers
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (an_restart === 1'b1) rs_n <= rs_n + 16'h1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [4:0] ra, input logic [15:0] exp);
        mm_u.xfer(5'h01, 2'b10, ra, 16'h0, d);
        chk(d, exp);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        mm_u.xfer(5'h01, 2'b01, ra, wd, d);
    endtask
    task automatic pl(input logic [3:0] v);
        @(posedge clk_sys) ev <= v;
        @(posedge clk_sys) ev <= 4'h0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Frames take about 1300 cycles; 60000 leaves room for all
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end
    // ==========================================================
    // Tests
    initial begin
        rstn = 1'b0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (12) @(posedge clk_sys);
        for (int i = 0; i < 13; i++) rc(RA[i], EX[i]);
        $display("test reset map done");
        wr(5'h04, 16'hffff);
        rc(5'h04, 16'hb1a0);
        wr(5'h04, 16'h3000);
        rc(5'h04, 16'h3000);
        @(posedge clk_sys) an_complete <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(adv_page, 16'h0);
        rc(5'h01, 16'h016c);
        $display("test advertisement done");
        wr(5'h07, 16'hffff);
        rc(5'h07, 16'hb7ff);
        pl(4'h1);
        rc(5'h07, 16'hbfff);
        pl(4'h1);
        chk(np_tx_page, 16'hb7ff);
        $display("test toggle done");
        base_page_rx <= 16'hffff;
        next_page_rx <= 16'h5a5a;
        pl(4'h4);
        rc(5'h05, 16'hf1e0);
        rc(5'h06, 16'h0006);
        rc(5'h06, 16'h0004);
        pl(4'h2);
        rc(5'h08, 16'h5a5a);
        rc(5'h06, 16'h0006);
        $display("test pages done");
        pl(4'h8);
        rc(5'h01, 16'h017c);
        rc(5'h01, 16'h016c);
        @(posedge clk_sys) link_up <= 1'b0;
        @(posedge clk_sys) link_up <= 1'b1;
        rc(5'h01, 16'h0168);
        rc(5'h01, 16'h016c);
        $display("test latched flags done");
        wr(5'h00, 16'h0200);
        chk(rs_n, 16'h0001);
        mm_u.xfer(5'h02, 2'b10, 5'h04, 16'h0, d);
        chk(d, 16'hffff);
        mm_u.xfer(5'h02, 2'b01, 5'h04, 16'hffff, d);
        mm_u.xfer(5'h01, 2'b11, 5'h04, 16'hffff, d);
        rc(5'h04, 16'h0);
        $display("test refusals done");
        rstn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(adv_page, 16'h01a0);
        chk(np_tx_page, 16'h2001);
        rstn <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rc(5'h07, 16'h2001);
        $display("test second reset done");
        close_out();
    end
endmodule
`default_nettype wire
